// ### verilog/txs_sequencer.v
`timescale 1ns/1ns
`include "txs_consts.vh"

// Overview of operation
// (RL1) ASK normal transmit runs unlimited, full current
// (RL2) ASK low current transmits, some regulators off
// (RL3) controller waits 2ms before low-current request
// (RL4) enable low standby, high active
// (RL5) request high idle, low transmit
// (RL6) complementary ready outputs, inactive while unlocked
// (RL7) loss of lock suppresses both ready outputs
// (RL8) controller writes setup while enable low
// (RL9) first enable holds 257us for calibration
// (RL10) later enables allow transmit after short wake; here only with single calibration on, otherwise each wake recalibrates
// (RL11) controller waits 250/110us before using request
// (RL12) request high: transmitter off, synthesiser running
// (RL13) request low powers section then ready
// (RL14) low-current first enable needs 2000us wait
// (RL15) enable framing: PA on after wake delay
// (RL16) enable low ends packet, all shut down
// (RL17) no enable framing for first low-current packet
// (RL18) unframed: ready once PLL stable
// (RL19) data valid 7us after ready
// (RL20) single calibration: repeat wake within 110us
// (RL21) RF power falls 3.5us after ready falls; here only once the section is off too, so lock loss keeps RF on
// (RL22) single calibration skips later calibrations
// (RL23) mode decode from enable, request, ASK, low-current
// (RL24) single calibration holds until reset command
// (RL25) inverted ready high idle, low transmitting
// (RL26) delays in clock cycles; reset clears history
module txs_sequencer #(
	parameter CNT_W      = 16,
	parameter CAL_CYC    = (`TXS_CAL_WAKE_NS * `TXS_CLK_MHZ + 999) / 1000,
	parameter REPEAT_CYC = (`TXS_REPEAT_WAKE_NS * `TXS_CLK_MHZ) / 1000
) (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// controller pins
	input  wire        chip_enable,
	input  wire        tx_request_n,
	output reg         tx_ready,
	output reg         tx_ready_n,
	// analog status
	input  wire        pll_lock,
	// power controls
	output reg         regulators_on,
	output reg         regulators_reduced,
	output reg         synth_on,
	output reg         tx_section_on,
	output reg         calibrating,
	output reg         tx_data_valid,
	output reg         rf_power_on,
	output reg  [2:0]  mode_code
);
	// one-hot sequencer states
	localparam [4:0] ST_STANDBY = 5'h01;
	localparam [4:0] ST_WAKE    = 5'h02;
	localparam [4:0] ST_IDLE    = 5'h04;
	localparam [4:0] ST_TXUP    = 5'h08;
	localparam [4:0] ST_TXON    = 5'h10;

	// short delays fit well under 4096 cycles
	localparam TXEN_FULL   = (`TXS_TXEN_NS * `TXS_CLK_MHZ + 999) / 1000;
	localparam RF_OFF_FULL = (`TXS_RF_OFF_NS * `TXS_CLK_MHZ + 999) / 1000;
	localparam SETTLE_FULL = (`TXS_PA_SETTLE_NS * `TXS_CLK_MHZ + 999) / 1000;
	// counts are cut to the counter width on purpose
	localparam [CNT_W-1:0] TXEN_CYC   = TXEN_FULL[CNT_W-1:0];
	localparam [CNT_W-1:0] RF_OFF_CYC = RF_OFF_FULL[CNT_W-1:0];
	localparam [CNT_W-1:0] SETTLE_CYC = SETTLE_FULL[CNT_W-1:0];
	localparam [CNT_W-1:0] CAL_LIM    = CAL_CYC[CNT_W-1:0];
	localparam [CNT_W-1:0] REP_LIM    = REPEAT_CYC[CNT_W-1:0];

	reg  [4:0]       state_q;
	reg  [4:0]       state_d;
	reg              scal_q;
	reg              lowcur_q;
	reg              ask_q;
	reg              caldone_q;
	reg              skip_cal_q;
	reg              rst_cmd_q;
	wire [2:0]       pins_s;
	wire             ce_s;
	wire             req_n_s;
	wire             lock_s;
	wire             wake_done;
	wire             settle_done;
	wire             txen_done;
	wire             rfoff_done;
	wire [CNT_W-1:0] wake_lim;
	wire             wr_go;
	wire [31:0]      status_w;
	wire [31:0]      ctrl_w;
	wire [31:0]      timing_w;
	reg  [2:0]       mode_d;

	// pins come from another party, so every one passes two flops
	txs_sync #(
		.W       (3),
		.RST_VAL (3'h2)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({pll_lock, tx_request_n, chip_enable}),
		.sync_out (pins_s)
	);
	assign ce_s    = pins_s[0];
	assign req_n_s = pins_s[1];
	assign lock_s  = pins_s[2];

	// wake length picked at enable rise from calibration history
	assign wake_lim = skip_cal_q ? REP_LIM : CAL_LIM; // [RL20] [RL22]

	// wake timer: runs only while waking with enable held
	txs_delay #(
		.CNT_W (CNT_W)
	) u_wake (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (state_q == ST_WAKE),
		.limit   (wake_lim),
		.done_q  (wake_done)
	); // [RL9] [RL10] [RL15] [RL26]

	// transmit section settle before ready may rise
	txs_delay #(
		.CNT_W (CNT_W)
	) u_settle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (state_q == ST_TXUP || state_q == ST_TXON),
		.limit   (SETTLE_CYC),
		.done_q  (settle_done)
	); // [RL13]

	// ready to valid data
	txs_delay #(
		.CNT_W (CNT_W)
	) u_txen (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (tx_ready),
		.limit   (TXEN_CYC),
		.done_q  (txen_done)
	); // [RL19]

	// ready fall to rf power off
	txs_delay #(
		.CNT_W (CNT_W)
	) u_rfoff (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (rf_power_on && !tx_ready && !tx_section_on),
		.limit   (RF_OFF_CYC),
		.done_q  (rfoff_done)
	); // [RL21]

	// sequencer next state
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_STANDBY: begin
				if (ce_s)
					state_d = ST_WAKE; // [RL4]
			end
			ST_WAKE: begin
				if (!ce_s)
					state_d = ST_STANDBY;
				else if (wake_done)
					state_d = ST_IDLE;
			end
			ST_IDLE: begin
				if (!ce_s)
					state_d = ST_STANDBY; // [RL16]
				else if (!req_n_s)
					state_d = ST_TXUP; // [RL5] [RL15] [RL18]
			end
			ST_TXUP: begin
				if (!ce_s)
					state_d = ST_STANDBY;
				else if (req_n_s)
					state_d = ST_IDLE; // [RL13]
				else if (settle_done && lock_s)
					state_d = ST_TXON; // [RL18]
			end
			ST_TXON: begin
				if (!ce_s)
					state_d = ST_STANDBY; // [RL16]
				else if (req_n_s)
					state_d = ST_IDLE; // [RL13]
				else if (!lock_s)
					state_d = ST_TXUP; // [RL7]
			end
			default: state_d = ST_STANDBY;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn)
			state_q <= ST_STANDBY;
		else
			state_q <= state_d;
	end

	// calibration history; a completed calibration is remembered only
	// when single calibration is on, otherwise every wake recalibrates
	always @(posedge aclk) begin
		if (!aresetn) begin
			caldone_q  <= 1'b0; // [RL26]
			skip_cal_q <= 1'b0;
		end else begin
			// a finishing calibration wins over a same-cycle reset command
			if (state_q == ST_WAKE && wake_done && !skip_cal_q && scal_q)
				caldone_q <= 1'b1; // [RL9]
			else if (rst_cmd_q)
				caldone_q <= 1'b0; // [RL24]
			if (state_q == ST_STANDBY)
				skip_cal_q <= scal_q && caldone_q && !rst_cmd_q; // [RL22] [RL24]
		end
	end

	// mode decode from the next state, so mode and regulators switch on one edge
	always @* begin
		if (!ce_s || state_d == ST_STANDBY)
			mode_d = `TXS_MODE_STANDBY; // [RL23]
		else if (state_d == ST_WAKE || state_d == ST_IDLE)
			mode_d = `TXS_MODE_IDLE;
		else if (!ask_q)
			mode_d = `TXS_MODE_FSK;
		else if (!lowcur_q)
			mode_d = `TXS_MODE_ASK_NORM;
		else
			mode_d = `TXS_MODE_ASK_LOW;
	end

	// registered pin and power outputs
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_ready           <= 1'b0;
			tx_ready_n         <= 1'b1;
			regulators_on      <= 1'b0;
			regulators_reduced <= 1'b0;
			synth_on           <= 1'b0;
			tx_section_on      <= 1'b0;
			calibrating        <= 1'b0;
			tx_data_valid      <= 1'b0;
			rf_power_on        <= 1'b0;
			mode_code          <= `TXS_MODE_STANDBY;
		end else begin
			// ready only while the section is up and the loop is locked
			tx_ready   <= (state_d == ST_TXON) && lock_s; // [RL6] [RL7]
			tx_ready_n <= !((state_d == ST_TXON) && lock_s); // [RL6] [RL25]
			regulators_on <= (state_d != ST_STANDBY); // [RL4] [RL1]
			// low-current ASK drops some regulators while transmitting;
			// no cap on burst length is imposed here
			regulators_reduced <= (state_d == ST_TXUP || state_d == ST_TXON) &&
				ask_q && lowcur_q; // [RL2]
			synth_on      <= (state_d != ST_STANDBY); // [RL12]
			tx_section_on <= (state_d == ST_TXUP || state_d == ST_TXON); // [RL12] [RL13]
			calibrating   <= (state_d == ST_WAKE) && !skip_cal_q; // [RL9]
			tx_data_valid <= tx_ready && txen_done && (state_d == ST_TXON); // [RL19]
			if (tx_section_on && tx_ready)
				rf_power_on <= 1'b1;
			else if (rfoff_done)
				rf_power_on <= 1'b0; // [RL21]
			mode_code <= mode_d; // [RL23]
		end
	end

	// axi write: both address and data must be present, taken together
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;

	// control register, reset command pulses for one cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			scal_q       <= `TXS_CTRL_SCAL_RST;
			lowcur_q     <= `TXS_CTRL_LOWCUR_RST;
			ask_q        <= `TXS_CTRL_ASK_RST;
			rst_cmd_q    <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TXS_RESP_OKAY;
		end else begin
			rst_cmd_q <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				if (s_axi_awaddr == `TXS_ADDR_CTRL) begin
					s_axi_bresp <= `TXS_RESP_OKAY;
					if (s_axi_wstrb[0]) begin
						scal_q   <= s_axi_wdata[`TXS_CTRL_SCAL]; // [RL24]
						lowcur_q <= s_axi_wdata[`TXS_CTRL_LOWCUR];
						ask_q    <= s_axi_wdata[`TXS_CTRL_ASK];
						rst_cmd_q <= s_axi_wdata[`TXS_CTRL_RSTCMD];
					end
				end else if (s_axi_awaddr == `TXS_ADDR_STATUS ||
					s_axi_awaddr == `TXS_ADDR_TIMING) begin
					s_axi_bresp <= `TXS_RESP_OKAY; // read-only, write ignored
				end else begin
					s_axi_bresp <= `TXS_RESP_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read views
	assign ctrl_w = {28'h0000000, 1'b0, ask_q, lowcur_q, scal_q};
	assign status_w = {19'h00000, req_n_s, ce_s, tx_section_on, rf_power_on,
		tx_data_valid, tx_ready, lock_s, calibrating, caldone_q, 1'b0, mode_code};
	assign timing_w = {CAL_LIM, REP_LIM};
	assign s_axi_arready = !s_axi_rvalid;

	// axi read: one cycle from address to data
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `TXS_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `TXS_RESP_OKAY;
			case (s_axi_araddr)
				`TXS_ADDR_CTRL:   s_axi_rdata <= ctrl_w;
				`TXS_ADDR_STATUS: s_axi_rdata <= status_w;
				`TXS_ADDR_TIMING: s_axi_rdata <= timing_w;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `TXS_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // txs_sequencer

// ### verilog/txs_consts.vh
`ifndef TXS_CONSTS_VH
`define TXS_CONSTS_VH

// clock rate
`define TXS_CLK_MHZ        100

// delay figures in nanoseconds
`define TXS_CAL_WAKE_NS    257000
`define TXS_REPEAT_WAKE_NS 110000
`define TXS_TXEN_NS        7000
`define TXS_RF_OFF_NS      3500
`define TXS_PA_SETTLE_NS   1000

// register byte addresses
`define TXS_ADDR_CTRL      12'h000
`define TXS_ADDR_STATUS    12'h004
`define TXS_ADDR_TIMING    12'h008

// control register fields
`define TXS_CTRL_SCAL      0
`define TXS_CTRL_LOWCUR    1
`define TXS_CTRL_ASK       2
`define TXS_CTRL_RSTCMD    3
`define TXS_CTRL_SCAL_RST  1'b1
`define TXS_CTRL_LOWCUR_RST 1'b0
`define TXS_CTRL_ASK_RST   1'b1

// status register fields
`define TXS_ST_MODE_LSB    0
`define TXS_ST_CALDONE     4
`define TXS_ST_CALIB       5
`define TXS_ST_LOCK        6
`define TXS_ST_READY       7
`define TXS_ST_DVALID      8
`define TXS_ST_RFON        9
`define TXS_ST_TXSEC       10
`define TXS_ST_CE          11
`define TXS_ST_REQN        12

// mode codes
`define TXS_MODE_STANDBY   3'h0
`define TXS_MODE_IDLE      3'h1
`define TXS_MODE_FSK       3'h2
`define TXS_MODE_ASK_NORM  3'h3
`define TXS_MODE_ASK_LOW   3'h4

// axi responses
`define TXS_RESP_OKAY      2'h0
`define TXS_RESP_SLVERR    2'h2

`endif

// ### verilog/txs_sync.v
`timescale 1ns/1ns
// two-flop synchroniser, one chain per bit
module txs_sync #(
	parameter W       = 1,
	parameter RST_VAL = 1
) (
	// clock and reset
	input  wire         aclk,
	input  wire         aresetn,
	// async in, synced out
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			// first flop feeds only the second one
			always @(posedge aclk) begin
				if (!aresetn) begin
					meta_q <= RST_VAL[i];
					sync_q <= RST_VAL[i];
				end else begin
					meta_q <= async_in[i];
					sync_q <= meta_q;
				end
			end
			assign sync_out[i] = sync_q;
		end
	endgenerate
endmodule // txs_sync

// ### verilog/txs_delay.v
`timescale 1ns/1ns
// level-run delay: done rises limit cycles after run rises, clears with run
module txs_delay #(
	parameter CNT_W = 16
) (
	// clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// control
	input  wire             run,
	input  wire [CNT_W-1:0] limit,
	output reg              done_q
);
	reg [CNT_W-1:0] cnt_q;

	// count while run holds; dropping run restarts from zero
	always @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_q  <= {CNT_W{1'b0}};
			done_q <= 1'b0;
		end else if (!done_q) begin
			cnt_q <= cnt_q + 1'b1;
			if (cnt_q + 1'b1 >= limit)
				done_q <= 1'b1;
		end
	end
endmodule // txs_delay

// ### sim/txs_sequencer_asserts.sv
`timescale 1ns/1ns
`include "txs_consts.vh"
// pin-level checks on the power-mode sequencer
module txs_chk #(
	parameter CAL_CYC = 25700
) (
	// clock and reset
	input wire       aclk,
	input wire       aresetn,
	// controller pins and lock
	input wire       chip_enable,
	input wire       tx_request_n,
	input wire       pll_lock,
	input wire       tx_ready,
	input wire       tx_ready_n,
	// power controls
	input wire       regulators_on,
	input wire       regulators_reduced,
	input wire       synth_on,
	input wire       tx_section_on,
	input wire       calibrating,
	input wire       tx_data_valid,
	input wire       rf_power_on,
	input wire [2:0] mode_code
);
	logic [15:0] rdy_q, off_q, cal_q;
	// run lengths of ready, of a dark transmit section, and of calibration
	always @(posedge aclk) begin
		rdy_q <= (aresetn && tx_ready) ? rdy_q + 16'h1 : 16'h0;
		off_q <= (!aresetn || tx_ready || tx_section_on) ? 16'h0 : off_q + 16'h1;
		cal_q <= (aresetn && calibrating) ? cal_q + 16'h1 : 16'h0;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_ready_pair: assert property (tx_ready_n == !tx_ready)
		else $error("ready outputs not complementary");
	a_lock_kill: assert property (!pll_lock [*4] |-> !tx_ready)
		else $error("ready while unlocked");
	a_standby_dark: assert property (!chip_enable [*5] |-> !regulators_on && !synth_on && mode_code == `TXS_MODE_STANDBY)
		else $error("not in standby with enable low");
	a_idle_dark: assert property ((chip_enable && tx_request_n) [*5] |-> !tx_section_on && !tx_ready)
		else $error("transmit section on while idle");
	a_ready_cause: assert property ($rose(tx_ready) |-> tx_section_on && regulators_on)
		else $error("ready without transmit section");
	a_rf_follow: assert property ($rose(tx_ready) |=> rf_power_on)
		else $error("rf power late after ready");
	a_data_delay: assert property ($rose(tx_data_valid) |-> tx_ready && rdy_q >= 16'h2BB && rdy_q <= 16'h2BD)
		else $error("data valid delay wrong");
	a_rf_off_gap: assert property ($fell(rf_power_on) |-> off_q >= 16'h15D && off_q <= 16'h547)
		else $error("rf off delay out of range");
	a_low_mode: assert property (regulators_reduced |-> mode_code == `TXS_MODE_ASK_LOW)
		else $error("reduced regulators outside low current");
	a_cal_len: assert property ($fell(calibrating) && regulators_on |-> cal_q >= CAL_CYC - 1 && cal_q <= CAL_CYC + 1)
		else $error("calibration wake length wrong");
	// main scenarios reached
	c_ready: cover property ($rose(tx_ready));
	c_low: cover property (regulators_reduced && tx_ready);
	c_cal: cover property ($fell(calibrating));
endmodule // txs_chk

bind txs_sequencer txs_chk #(.CAL_CYC(CAL_CYC)) u_chk (.aclk, .aresetn, .chip_enable, .tx_request_n, .pll_lock,
	.tx_ready, .tx_ready_n, .regulators_on, .regulators_reduced, .synth_on, .tx_section_on, .calibrating,
	.tx_data_valid, .rf_power_on, .mode_code);

// ### sim/txs_bbc.sv
`timescale 1ns/1ns
// baseband controller model driving enable and transmit request
module txs_bbc (
	// clock
	input  wire  aclk,
	// answer from the block
	input  wire  tx_ready,
	// pins toward the block
	output logic chip_enable = 1'h0,
	output logic tx_request_n = 1'h1
);
	// both pins change together just after an edge
	task drive(input logic ce, input logic rqn);
		@(posedge aclk);
		chip_enable <= ce;
		tx_request_n <= rqn;
	endtask
	// raise enable with the request low when framed, idle otherwise, then wait the wake time given
	task wake(input logic framed, input int cyc);
		drive(1'h1, !framed);
		repeat (cyc) @(posedge aclk);
	endtask
	// count edges until ready shows, bounded so a dead block cannot hang us
	task wait_ready(output int n);
		n = 0;
		while (tx_ready !== 1'h1 && n < 5000) begin
			@(posedge aclk);
			n++;
		end
	endtask
endmodule // txs_bbc

// ### sim/testbench.sv
`timescale 1ns/1ns
`include "txs_consts.vh"
// bench for the power-mode sequencer, wake counts shortened
module testbench;
	localparam int CAL = 40;
	localparam int REP = 20;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pll_lock = 1'h1;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         chip_enable, tx_request_n, tx_ready, tx_ready_n, regulators_on, regulators_reduced;
	wire         synth_on, tx_section_on, calibrating, tx_data_valid, rf_power_on;
	wire  [2:0]  mode_code;
	logic [31:0] rd;
	logic [1:0]  rs;
	int          mismatches = 0, n_tests = 0, n;
	time         last_cal = 0, t0 = 0;
	// design and controller model
	txs_sequencer #(.CAL_CYC(CAL), .REPEAT_CYC(REP)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .chip_enable, .tx_request_n, .tx_ready, .tx_ready_n, .pll_lock, .regulators_on,
		.regulators_reduced, .synth_on, .tx_section_on, .calibrating, .tx_data_valid, .rf_power_on, .mode_code);
	txs_bbc bbc (.aclk, .tx_ready, .chip_enable, .tx_request_n);
	// clock, calibration monitor, hang guard
	always #5 aclk = ~aclk;
	always @(posedge aclk) if (calibrating === 1'h1) last_cal <= $time;
	initial begin
		#200000;
		mismatches++;
		tally_and_finish;
	end
	task tally_and_finish;
		$display("compares %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one write: address and data offered together, held until taken
	task axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (s_axi_awready !== 1'h1);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		while (s_axi_bvalid !== 1'h1) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		while (s_axi_rvalid !== 1'h1) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// drop enable, then regulators, synthesiser and ready must be off, mode standby
	task sleep(input logic rqn);
		bbc.drive(1'h0, rqn);
		repeat (6) @(posedge aclk);
		chk({regulators_on, synth_on, tx_ready, tx_ready_n, mode_code}, 7'h08);
	endtask
	// reset values, read-only status, unmapped place
	task t_regs;
		axr(`TXS_ADDR_CTRL, rd, rs);
		chk(rd, 32'h5);
		axr(`TXS_ADDR_STATUS, rd, rs);
		chk(rd, 32'h1040);
		axr(`TXS_ADDR_TIMING, rd, rs);
		chk(rd, {CAL[15:0], REP[15:0]});
		axw(`TXS_ADDR_STATUS, 32'hFFFF, rs);
		chk(rs, `TXS_RESP_OKAY);
		axr(12'h010, rd, rs);
		chk(rs, `TXS_RESP_SLVERR);
		axw(12'h010, 32'h0, rs);
		chk(rs, `TXS_RESP_SLVERR);
	endtask
	// calibrating wake, request-framed packet, lock drop, release
	task t_first;
		axw(`TXS_ADDR_CTRL, 32'h5, rs);
		bbc.wake(1'h0, CAL + 20);
		chk(last_cal > t0, 1'h1);
		chk({mode_code, tx_section_on, tx_ready_n, synth_on}, 6'h0B);
		bbc.drive(1'h1, 1'h0);
		bbc.wait_ready(n);
		chk(n >= 100 && n <= 115, 1'h1);
		chk({mode_code, tx_ready, tx_ready_n, regulators_reduced}, 6'h1C);
		repeat (690) @(posedge aclk);
		chk(tx_data_valid, 1'h0);
		repeat (15) @(posedge aclk);
		chk(tx_data_valid, 1'h1);
		pll_lock <= 1'h0;
		repeat (6) @(posedge aclk);
		chk({tx_ready, tx_ready_n, tx_data_valid}, 3'h2);
		pll_lock <= 1'h1;
		repeat (120) @(posedge aclk);
		chk(tx_ready, 1'h1);
		bbc.drive(1'h1, 1'h1);
		repeat (6) @(posedge aclk);
		chk({tx_ready, tx_ready_n, tx_section_on, rf_power_on}, 4'h5);
		repeat (400) @(posedge aclk);
		chk({rf_power_on, synth_on}, 2'h1);
		sleep(1'h1);
	endtask
	// enable-framed repeats skip calibration and answer after the short wake plus settle
	task t_repeat;
		repeat (2) begin
			t0 = $time;
			bbc.wake(1'h1, 0);
			bbc.wait_ready(n);
			chk(last_cal > t0, 1'h0);
			chk(n >= REP + 100 && n <= REP + 112, 1'h1);
			sleep(1'h0);
		end
		bbc.drive(1'h0, 1'h1);
	endtask
	// reset command clears history: one more calibration, then skips again
	task t_recal;
		axw(`TXS_ADDR_CTRL, 32'hD, rs);
		for (int i = 0; i < 2; i++) begin
			t0 = $time;
			bbc.wake(1'h0, CAL + 20);
			chk(last_cal > t0, i == 0);
			sleep(1'h1);
		end
		axr(`TXS_ADDR_CTRL, rd, rs);
		chk(rd, 32'h5);
	endtask
	// mid-run reset forgets the calibration history, so the next wake calibrates
	task t_reset;
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		axr(`TXS_ADDR_STATUS, rd, rs);
		chk(rd[`TXS_ST_CALDONE], 1'h0);
		t0 = $time;
		bbc.wake(1'h0, CAL + 20);
		chk(last_cal > t0, 1'h1);
		sleep(1'h1);
	endtask
	// every transmit mode, single calibration off so each wake calibrates
	task t_modes;
		for (int i = 0; i < 3; i++) begin
			axw(`TXS_ADDR_CTRL, {29'h0, i > 0, i == 2, 1'h0}, rs);
			t0 = $time;
			bbc.wake(1'h0, CAL + 20);
			bbc.drive(1'h1, 1'h0);
			bbc.wait_ready(n);
			chk({last_cal > t0, mode_code, regulators_reduced}, {1'h1, 3'(`TXS_MODE_FSK + i), i == 2});
			sleep(1'h1);
		end
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs;
		t_first;
		t_repeat;
		t_recal;
		t_reset;
		t_modes;
		tally_and_finish;
	end
endmodule // testbench
